// ==== hdl/spp_pkg.sv ====
`default_nettype none

package spp_pkg;

    // ==========================================================
    // Register bus
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    localparam logic [7:0] OFS_PLAN  = 8'h20;
    localparam logic [7:0] OFS_AUX   = 8'h22;
    localparam logic [7:0] OFS_BCTL  = 8'h24;
    localparam logic [7:0] OFS_BCFG  = 8'h25;
    localparam logic [7:0] OFS_BSTAT = 8'h26;
    localparam logic [7:0] OFS_SIG   = 8'h40;
    localparam logic [7:0] OFS_CAUSE = 8'h41;

    // ==========================================================
    // Reset values and write masks
    localparam logic [15:0] PLAN_RST   = 16'h11DF;
    localparam logic [15:0] PLAN_WMASK = 16'hFFDF;
    localparam logic [15:0] AUX_RST    = 16'h0022;
    localparam logic [15:0] AUX_WMASK  = 16'h00BF;
    localparam logic [7:0]  BCTL_RST   = 8'h00;
    localparam logic [7:0]  BCTL_WMASK = 8'h0F;
    localparam logic [7:0]  BCFG_RST   = 8'h02;
    localparam logic [7:0]  BCFG_WMASK = 8'h03;
    localparam logic [7:0]  SIG_KEY1   = 8'h57;
    localparam logic [7:0]  SIG_KEY2   = 8'hA8;

    // ==========================================================
    // Field positions
    localparam int unsigned PLAN_ARM   = 15;
    localparam int unsigned PLAN_BIAS  = 10;
    localparam int unsigned PLAN_CONV  = 9;
    localparam int unsigned PLAN_LDO   = 8;
    localparam int unsigned PLAN_SYS   = 7;
    localparam int unsigned PLAN_MAIN  = 4;
    localparam int unsigned PLAN_USBRF = 3;
    localparam int unsigned PLAN_CORE  = 2;
    localparam int unsigned PLAN_SMALL = 1;
    localparam int unsigned PLAN_FLASH = 0;
    localparam int unsigned AUX_CONV   = 7;
    localparam int unsigned BCTL_LIE   = 3;
    localparam int unsigned BCTL_ULIE  = 2;
    localparam int unsigned BCTL_MON   = 1;
    localparam int unsigned BCTL_DUAL  = 0;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned LDO_SETTLE_NS = 1000;
    localparam int unsigned CLK_SETTLE_NS = 2000;
    localparam int unsigned WAKE_RST_NS   = 500;
    localparam int unsigned SAFE_WIN_NS   = 800;
    localparam logic [7:0] LDO_CYC  = 8'((LDO_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CLK_CYC  = 8'((CLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RST_CYC  = 8'((WAKE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SAFE_CYC = 8'((SAFE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // Types
    typedef enum logic [7:0] {
        ST_RUN    = 8'h01,
        ST_IDLE   = 8'h02,
        ST_HALT   = 8'h04,
        ST_SLEEP  = 8'h08,
        ST_SHUT   = 8'h10,
        ST_WK_LDO = 8'h20,
        ST_WK_CLK = 8'h40,
        ST_WK_RST = 8'h80
    } spp_state_e;

    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } spp_bus_req_s;

    typedef struct packed {
        logic       main_sram_retain;
        logic       usb_rf_cfg_retain;
        logic       core_periph_retain;
        logic       small_sram_retain;
        logic       flash_power_keep;
        logic       main_ldo_en;
        logic       sys_power_en;
        logic       converter_enable;
        logic       converter_bias_enable;
        logic       direct_supply_en;
        logic       aux_converter_enable;
        logic [2:0] ulp_regulator_trim;
    } spp_supply_s;

    typedef struct packed {
        logic       batt_monitor_enable;
        logic       precise_detect_enable;
        logic [2:0] monitor_threshold;
        logic [1:0] precise_threshold;
        logic       batt_irq;
        logic       batt_nmi;
    } spp_batt_s;

    typedef struct packed {
        logic core_run;
        logic clk_sys_en;
        logic wake_system_reset;
    } spp_seq_s;

endpackage : spp_pkg

`default_nettype wire

// ==== hdl/spp_sleep_power_planner.sv ====
// Function
// [RULE1] Plan bit 4 keeps main SRAM on dual supply in planned sleep, else aux off
// [RULE2] Plan bit 3 keeps USB and radio configuration on dual supply in sleep
// [RULE3] Plan bit 2 keeps core and basic peripherals on dual supply in sleep
// [RULE4] Plan bit 1 keeps small SRAM on dual supply in planned sleep
// [RULE5] Plan bit 0 keeps flash powered, else flash is off during sleep
// [RULE6] Supply selections are held as a plan, applied only on low-power entry
// [RULE7] Software keeps aux reserved bits 5..3; bits 11..8 ignore writes
// [RULE8] Aux bit 7 enables the low-power auxiliary converter, reset zero
// [RULE9] Aux bits 2..0 trim the ultra-low-power regulator, typical 010b
// [RULE10] Battery control bits 3 and 2 enable low and ultra-low interrupts
// [RULE11] Battery control bit 1 selects the low-power monitor, else precise path
// [RULE12] Bit 0 is monitor top threshold bit, or precise detect enable
// [RULE13] Ultra-low with both enables set raises a non-maskable interrupt instead
// [RULE14] Precise mode threshold field picks ultra-low and low pair, reset 10b
// [RULE15] Monitor mode threshold is bit 0 above the 2-bit field, three bits
// [RULE16] Status bit 1 battery low; bit 0 ultra-low only in precise mode
// [RULE17] Idle stops core only; any wake resumes the core at once
// [RULE18] Halt stops clocks; wake restarts clocks before releasing the core
// [RULE19] Sleep wake turns on regulator, then clocks, then releases core
// [RULE20] Shutdown wake issues full system reset and sets a reset cause flag
// [RULE21] Software uses deep-sleep flag and plan before the wait instruction
// [RULE22] Software unlocks with 0x57 then 0xA8 before converter bit changes
// [RULE23] Plan arm bit 15 executes on next sleep entry, then clears itself
// [RULE24] Converter and bias bits act at once; converter on turns direct supply off
// [RULE25] Protected fields accept writes only inside the unlocked access window
`timescale 1ns/1ps
`default_nettype none

module spp_sleep_power_planner (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  srst,
    // Register port
    input  wire spp_pkg::spp_bus_req_s bus_req,
    output var  logic [15:0]           rd_data,
    // Core handshake
    input  wire logic                  wait_req,
    input  wire logic                  deep_sleep_flag,
    // Asynchronous inputs
    input  wire logic                  wake_event,
    input  wire logic                  batt_low_cmp,
    input  wire logic                  batt_ultralow_cmp,
    // Power, battery and sequencing outputs
    output var  spp_pkg::spp_supply_s  supply,
    output var  spp_pkg::spp_batt_s    batt,
    output var  spp_pkg::spp_seq_s     seq
);
    import spp_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        spp_state_e  fsm;
        logic [7:0]  cnt;
        logic [15:0] plan;
        logic [15:0] aux;
        logic [7:0]  bctl;
        logic [7:0]  bcfg;
        logic [15:0] applied;
        logic        key1_seen;
        logic [7:0]  safe_cnt;
        logic        reset_cause_flag;
        logic [3:0]  sy_wake;
        logic [3:0]  sy_low;
        logic [3:0]  sy_ulow;
        logic [15:0] rdata;
        spp_supply_s supply;
        spp_batt_s   batt;
        spp_seq_s    seq;
    } spp_regs_s;

    spp_regs_s st_r;
    spp_regs_s st_nxt;

    // ==========================================================
    // Helpers
    // Chain {filtered, s2, s1, s0}; change taken when s1 and s2 agree
    function automatic logic [3:0] sync_step(input logic pin, input logic [3:0] cur);
        logic filt;
        filt = (cur[1] == cur[2]) ? cur[1] : cur[3];
        return {filt, cur[1], cur[0], pin};
    endfunction : sync_step

    function automatic logic [15:0] masked_write(input logic [15:0] old,
                                                 input logic [15:0] wd,
                                                 input logic [15:0] mask);
        return (old & ~mask) | (wd & mask);
    endfunction : masked_write

    // ==========================================================
    // Next state
    logic        wake_lvl;
    logic        low_stat;
    logic        ulow_stat;
    logic        unlocked;
    logic        prot_wr;
    logic [7:0]  bstat;
    logic        lowpwr;

    always_comb begin
        st_nxt    = st_r;
        wake_lvl  = st_r.sy_wake[3];
        unlocked  = (st_r.safe_cnt != 8'h00);
        prot_wr   = bus_req.wr && unlocked;  // see [RULE25]

        // Input synchronisers
        st_nxt.sy_wake = sync_step(wake_event, st_r.sy_wake);
        st_nxt.sy_low  = sync_step(batt_low_cmp, st_r.sy_low);
        st_nxt.sy_ulow = sync_step(batt_ultralow_cmp, st_r.sy_ulow);

        // Battery status, gated by the active detection path
        low_stat  = st_r.sy_low[3] &&
                    (st_r.bctl[BCTL_MON] || st_r.bctl[BCTL_DUAL]);  // see [RULE16]
        ulow_stat = st_r.sy_ulow[3] && !st_r.bctl[BCTL_MON] &&
                    st_r.bctl[BCTL_DUAL];  // see [RULE16]
        bstat     = {6'h00, low_stat, ulow_stat};

        // Protected access window
        if (st_r.safe_cnt != 8'h00) begin
            st_nxt.safe_cnt = st_r.safe_cnt - 8'h01;
        end
        if (bus_req.wr && bus_req.addr == OFS_SIG) begin
            if (st_r.key1_seen && bus_req.wdata[7:0] == SIG_KEY2) begin
                st_nxt.safe_cnt  = SAFE_CYC;  // see [RULE22]
                st_nxt.key1_seen = 1'b0;
            end else begin
                st_nxt.key1_seen = (bus_req.wdata[7:0] == SIG_KEY1);
                st_nxt.safe_cnt  = 8'h00;
            end
        end

        // Register writes
        if (prot_wr) begin
            case (bus_req.addr)
                OFS_PLAN: begin
                    st_nxt.plan = masked_write(st_r.plan, bus_req.wdata, PLAN_WMASK);  // see [RULE6]
                end
                OFS_AUX: begin
                    st_nxt.aux = masked_write(st_r.aux, bus_req.wdata, AUX_WMASK);  // see [RULE7]
                end
                OFS_BCTL: begin
                    st_nxt.bctl = 8'(masked_write({8'h00, st_r.bctl}, bus_req.wdata,
                                                  {8'h00, BCTL_WMASK}));
                end
                OFS_BCFG: begin
                    st_nxt.bcfg = 8'(masked_write({8'h00, st_r.bcfg}, bus_req.wdata,
                                                  {8'h00, BCFG_WMASK}));
                end
                default: begin
                end
            endcase
        end
        if (bus_req.wr && bus_req.addr == OFS_CAUSE && bus_req.wdata[0]) begin
            st_nxt.reset_cause_flag = 1'b0;
        end

        // Register reads, data in the following cycle
        st_nxt.rdata = 16'h0000;
        if (bus_req.rd) begin
            case (bus_req.addr)
                OFS_PLAN:  st_nxt.rdata = st_r.plan;
                OFS_AUX:   st_nxt.rdata = st_r.aux;
                OFS_BCTL:  st_nxt.rdata = {8'h00, st_r.bctl};
                OFS_BCFG:  st_nxt.rdata = {8'h00, st_r.bcfg};
                OFS_BSTAT: st_nxt.rdata = {8'h00, bstat};
                OFS_SIG:   st_nxt.rdata = {15'h0000, unlocked};
                OFS_CAUSE: st_nxt.rdata = {15'h0000, st_r.reset_cause_flag};
                default:   st_nxt.rdata = 16'h0000;
            endcase
        end

        // Power mode sequencer
        if (st_r.cnt != 8'h00) begin
            st_nxt.cnt = st_r.cnt - 8'h01;
        end
        case (st_r.fsm)
            ST_RUN: begin
                if (wait_req) begin
                    if (!deep_sleep_flag) begin
                        st_nxt.fsm = ST_IDLE;  // see [RULE21]
                    end else if (st_r.plan[PLAN_ARM]) begin
                        st_nxt.applied        = st_r.plan;  // see [RULE6]
                        st_nxt.plan[PLAN_ARM] = 1'b0;  // see [RULE23]
                        st_nxt.fsm = st_r.plan[PLAN_CORE] ? ST_SLEEP : ST_SHUT;
                    end else begin
                        st_nxt.fsm = ST_HALT;
                    end
                end
            end
            ST_IDLE: begin
                if (wake_lvl) begin
                    st_nxt.fsm = ST_RUN;  // see [RULE17]
                end
            end
            ST_HALT: begin
                if (wake_lvl) begin
                    st_nxt.fsm = ST_WK_CLK;  // see [RULE18]
                    st_nxt.cnt = CLK_CYC;
                end
            end
            ST_SLEEP: begin
                if (wake_lvl) begin
                    st_nxt.fsm = ST_WK_LDO;  // see [RULE19]
                    st_nxt.cnt = LDO_CYC;
                end
            end
            ST_SHUT: begin
                if (wake_lvl) begin
                    st_nxt.fsm = ST_WK_RST;  // see [RULE20]
                    st_nxt.cnt = RST_CYC;
                end
            end
            ST_WK_LDO: begin
                if (st_r.cnt == 8'h01) begin
                    st_nxt.fsm = ST_WK_CLK;  // see [RULE19]
                    st_nxt.cnt = CLK_CYC;
                end
            end
            ST_WK_CLK: begin
                if (st_r.cnt == 8'h01) begin
                    st_nxt.fsm = ST_RUN;  // see [RULE18]
                end
            end
            ST_WK_RST: begin
                st_nxt.reset_cause_flag = 1'b1;  // see [RULE20]
                if (st_r.cnt == 8'h01) begin
                    st_nxt.fsm = ST_RUN;
                end
            end
            default: begin
                st_nxt.fsm = ST_RUN;
            end
        endcase

        // Supply outputs
        lowpwr = (st_nxt.fsm == ST_SLEEP) || (st_nxt.fsm == ST_SHUT);
        st_nxt.supply.main_sram_retain   = !lowpwr || st_nxt.applied[PLAN_MAIN];   // see [RULE1]
        st_nxt.supply.usb_rf_cfg_retain  = !lowpwr ||
            (st_nxt.applied[PLAN_USBRF] && st_nxt.fsm == ST_SLEEP);                // see [RULE2]
        st_nxt.supply.core_periph_retain = !lowpwr || st_nxt.fsm == ST_SLEEP;      // see [RULE3]
        st_nxt.supply.small_sram_retain  = !lowpwr || st_nxt.applied[PLAN_SMALL];  // see [RULE4]
        st_nxt.supply.flash_power_keep   = !lowpwr || st_nxt.applied[PLAN_FLASH];  // see [RULE5]
        st_nxt.supply.main_ldo_en        = !lowpwr;  // see [RULE19]
        st_nxt.supply.sys_power_en       = !lowpwr || st_nxt.applied[PLAN_SYS];
        st_nxt.supply.converter_enable      = st_nxt.plan[PLAN_CONV];   // see [RULE24]
        st_nxt.supply.converter_bias_enable = st_nxt.plan[PLAN_BIAS];   // see [RULE24]
        st_nxt.supply.direct_supply_en      = !st_nxt.plan[PLAN_CONV];  // see [RULE24]
        st_nxt.supply.aux_converter_enable  = st_nxt.aux[AUX_CONV];     // see [RULE8]
        st_nxt.supply.ulp_regulator_trim    = st_nxt.aux[2:0];          // see [RULE9]

        // Battery outputs
        st_nxt.batt.batt_monitor_enable   = st_nxt.bctl[BCTL_MON];  // see [RULE11]
        st_nxt.batt.precise_detect_enable = !st_nxt.bctl[BCTL_MON] &&
                                            st_nxt.bctl[BCTL_DUAL];  // see [RULE12]
        st_nxt.batt.monitor_threshold = st_nxt.bctl[BCTL_MON] ?
            {st_nxt.bctl[BCTL_DUAL], st_nxt.bcfg[1:0]} : 3'h0;  // see [RULE15]
        st_nxt.batt.precise_threshold = st_nxt.bctl[BCTL_MON] ?
            2'h0 : st_nxt.bcfg[1:0];  // see [RULE14]
        st_nxt.batt.batt_nmi = ulow_stat && st_r.bctl[BCTL_LIE] &&
                               st_r.bctl[BCTL_ULIE];  // see [RULE13]
        st_nxt.batt.batt_irq = !st_nxt.batt.batt_nmi &&
            ((low_stat && st_r.bctl[BCTL_LIE]) ||
             (ulow_stat && st_r.bctl[BCTL_ULIE]));  // see [RULE10]

        // Sequencing outputs
        st_nxt.seq.core_run   = (st_nxt.fsm == ST_RUN);
        st_nxt.seq.clk_sys_en = (st_nxt.fsm == ST_RUN) || (st_nxt.fsm == ST_IDLE) ||
                                (st_nxt.fsm == ST_WK_CLK) || (st_nxt.fsm == ST_WK_RST);
        st_nxt.seq.wake_system_reset = (st_nxt.fsm == ST_WK_RST);  // see [RULE20]
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_r <= '{
                fsm:              ST_RUN,
                cnt:              8'h00,
                plan:             PLAN_RST,
                aux:              AUX_RST,
                bctl:             BCTL_RST,
                bcfg:             BCFG_RST,
                applied:          PLAN_RST,
                key1_seen:        1'b0,
                safe_cnt:         8'h00,
                reset_cause_flag: 1'b0,
                sy_wake:          4'h0,
                sy_low:           4'h0,
                sy_ulow:          4'h0,
                rdata:            16'h0000,
                supply:           '{main_sram_retain: 1'b1, usb_rf_cfg_retain: 1'b1,
                                    core_periph_retain: 1'b1, small_sram_retain: 1'b1,
                                    flash_power_keep: 1'b1, main_ldo_en: 1'b1,
                                    sys_power_en: 1'b1, converter_enable: 1'b0,
                                    converter_bias_enable: 1'b0, direct_supply_en: 1'b1,
                                    aux_converter_enable: 1'b0,
                                    ulp_regulator_trim: AUX_RST[2:0]},
                batt:             '{batt_monitor_enable: 1'b0, precise_detect_enable: 1'b0,
                                    monitor_threshold: 3'h0,
                                    precise_threshold: BCFG_RST[1:0],
                                    batt_irq: 1'b0, batt_nmi: 1'b0},
                seq:              '{core_run: 1'b1, clk_sys_en: 1'b1,
                                    wake_system_reset: 1'b0}
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign rd_data = st_r.rdata;
    assign supply  = st_r.supply;
    assign batt    = st_r.batt;
    assign seq     = st_r.seq;

endmodule : spp_sleep_power_planner

`default_nettype wire

// ==== dv/spp_power_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module spp_power_chk (
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  srst,
    // Register port
    input wire spp_pkg::spp_bus_req_s bus_req,
    input wire logic [15:0]           rd_data,
    // Core and async inputs
    input wire logic                  wait_req,
    input wire logic                  deep_sleep_flag,
    input wire logic                  wake_event,
    input wire logic                  batt_low_cmp,
    input wire logic                  batt_ultralow_cmp,
    // Outputs
    input wire spp_pkg::spp_supply_s  supply,
    input wire spp_pkg::spp_batt_s    batt,
    input wire spp_pkg::spp_seq_s     seq
);
    import spp_pkg::*;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    // ==========================================================
    // Assertions
    a_rd_data_idle: assert property (!bus_req.rd |=> rd_data == 16'h0000)
        else $error("read data not zero outside read slot");
    a_conv_direct_off: assert property (supply.converter_enable |-> !supply.direct_supply_en)
        else $error("direct supply on while converter enabled");
    a_run_full_supply: assert property (seq.core_run |-> &{supply.main_sram_retain,
        supply.usb_rf_cfg_retain, supply.core_periph_retain, supply.small_sram_retain,
        supply.flash_power_keep, supply.main_ldo_en}) else $error("plan applied while running");
    a_nmi_not_irq: assert property (batt.batt_nmi |-> !batt.batt_irq)
        else $error("ordinary interrupt beside non-maskable one");
    a_idle_entry: assert property (wait_req && !deep_sleep_flag && seq.core_run
        |=> !seq.core_run && seq.clk_sys_en) else $error("idle entry wrong");
    a_deep_entry: assert property (wait_req && deep_sleep_flag && seq.core_run
        |=> !seq.core_run && !seq.clk_sys_en) else $error("deep entry kept clocks");
    a_ldo_before_clk: assert property ($rose(supply.main_ldo_en) && !seq.clk_sys_en
        |-> !seq.clk_sys_en[*8] ##13 seq.clk_sys_en) else $error("regulator settle wrong");
    a_clk_before_core: assert property ($rose(seq.clk_sys_en) && !seq.wake_system_reset
        |-> ##40 seq.core_run) else $error("clock settle wrong");
    a_core_needs_clk: assert property ($rose(seq.core_run) |-> $past(seq.clk_sys_en))
        else $error("core released before clocks");
    a_wake_reset_len: assert property ($rose(seq.wake_system_reset)
        |-> seq.wake_system_reset[*8] ##1 seq.wake_system_reset ##1 seq.wake_system_reset
        ##1 !seq.wake_system_reset) else $error("wake reset length wrong");

    // ==========================================================
    // Coverage
    c_wake_reset: cover property ($rose(seq.wake_system_reset));
    c_nmi:        cover property ($rose(batt.batt_nmi));
    c_converter:  cover property ($rose(supply.converter_enable));
    c_sleep_wake: cover property ($rose(supply.main_ldo_en));

endmodule : spp_power_chk

bind spp_sleep_power_planner spp_power_chk u_chk (
    .core_clk(core_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
    .wait_req(wait_req), .deep_sleep_flag(deep_sleep_flag), .wake_event(wake_event),
    .batt_low_cmp(batt_low_cmp), .batt_ultralow_cmp(batt_ultralow_cmp),
    .supply(supply), .batt(batt), .seq(seq)
);

`default_nettype wire

// ==== dv/spp_sleep_power_planner_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module spp_sleep_power_planner_tb_top;
    import spp_pkg::*;

    logic                core_clk, srst, wait_req, deep_sleep_flag;
    logic                wake_event, batt_low_cmp, batt_ultralow_cmp;
    spp_bus_req_s        bus_req;
    logic [15:0]         rd_data, rv;
    logic                wsr_seen;
    spp_supply_s         supply;
    spp_batt_s           batt;
    spp_seq_s            seq;
    int                  errors, cmp_count;
    logic [7:0]  ofs [6] = '{OFS_PLAN, OFS_AUX, OFS_BCTL, OFS_BCFG, OFS_BSTAT, 8'h30};
    logic [15:0] rsv [6] = '{PLAN_RST, AUX_RST, 16'(BCTL_RST), 16'(BCFG_RST), 16'h0000, 16'h0000};

    spp_sleep_power_planner DUT (
        .core_clk(core_clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
        .wait_req(wait_req), .deep_sleep_flag(deep_sleep_flag), .wake_event(wake_event),
        .batt_low_cmp(batt_low_cmp), .batt_ultralow_cmp(batt_ultralow_cmp),
        .supply(supply), .batt(batt), .seq(seq)
    );

    always #25 core_clk = ~core_clk;

    // ==========================================================
    // Tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk) begin
            bus_req.addr <= a; bus_req.wdata <= d; bus_req.wr <= 1'b1;
        end
        @(posedge core_clk) bus_req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk) begin
            bus_req.addr <= a; bus_req.rd <= 1'b1;
        end
        @(posedge core_clk) bus_req.rd <= 1'b0;
        #1 d = rd_data;
    endtask : rd

    task automatic unlock();
        wr(OFS_SIG, 16'h0057);
        wr(OFS_SIG, 16'h00A8);
    endtask : unlock

    task automatic enter(input logic deep);
        @(posedge core_clk) begin
            wait_req <= 1'b1; deep_sleep_flag <= deep;
        end
        @(posedge core_clk) wait_req <= 1'b0;
        #1;
    endtask : enter

    task automatic wake_up();
        int n;
        n = 0;
        wsr_seen = 1'b0;
        @(posedge core_clk) wake_event <= 1'b1;
        #1;
        while (seq.core_run !== 1'b1 && n < 300) begin
            wsr_seen |= seq.wake_system_reset;
            @(posedge core_clk);
            #1 n++;
        end
        chk(16'(n < 300), 16'h0001);
        @(posedge core_clk) wake_event <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask : wake_up

    task automatic wrap_up();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Tests
    initial begin
        core_clk = 1'b0; srst = 1'b1; bus_req = '0; wait_req = 1'b0; deep_sleep_flag = 1'b0;
        wake_event = 1'b0; batt_low_cmp = 1'b0; batt_ultralow_cmp = 1'b0;
        errors = 0; cmp_count = 0;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(ofs[i], rv);
            chk(rv, rsv[i]);
        end
        wr(OFS_PLAN, 16'h17DF);
        rd(OFS_PLAN, rv);
        chk(rv, PLAN_RST);
        unlock();
        rd(OFS_SIG, rv);
        chk(rv, 16'h0001);
        wr(OFS_PLAN, 16'h17DF);
        wr(OFS_AUX, 16'hFFFF);
        #1 chk(16'({supply.converter_bias_enable, supply.converter_enable,
                    supply.direct_supply_en}), 16'h0006);
        chk(16'({supply.aux_converter_enable, supply.ulp_regulator_trim}), 16'h000F);
        rd(OFS_AUX, rv);
        chk(rv, (16'hFFFF & AUX_WMASK) | (AUX_RST & ~AUX_WMASK));
        repeat (20) @(posedge core_clk);
        rd(OFS_SIG, rv);
        chk(rv, 16'h0000);
        unlock();
        wr(OFS_PLAN, 16'h11DF);
        wr(OFS_BCTL, 16'h000D);
        wr(OFS_BCFG, 16'h0001);
        #1 chk(16'(supply.direct_supply_en), 16'h0001);
        chk(16'({batt.precise_detect_enable, batt.precise_threshold}), 16'h0005);
        @(posedge core_clk) begin
            batt_low_cmp <= 1'b1; batt_ultralow_cmp <= 1'b1;
        end
        repeat (8) @(posedge core_clk);
        rd(OFS_BSTAT, rv);
        chk(rv, 16'h0003);
        chk(16'({batt.batt_irq, batt.batt_nmi}), 16'h0001);
        unlock();
        wr(OFS_BCTL, 16'h0009);
        repeat (3) @(posedge core_clk);
        #1 chk(16'({batt.batt_irq, batt.batt_nmi}), 16'h0002);
        unlock();
        wr(OFS_BCTL, 16'h0003);
        repeat (3) @(posedge core_clk);
        #1 chk(16'({batt.batt_monitor_enable, batt.monitor_threshold, batt.precise_threshold,
                    batt.precise_detect_enable, batt.batt_irq}), 16'h00D0);
        rd(OFS_BSTAT, rv);
        chk(rv, 16'h0002);
        @(posedge core_clk) begin
            batt_low_cmp <= 1'b0; batt_ultralow_cmp <= 1'b0;
        end
        enter(1'b0);
        chk(16'({seq.core_run, seq.clk_sys_en}), 16'h0001);
        wake_up();
        enter(1'b1);
        chk(16'({seq.core_run, seq.clk_sys_en}), 16'h0000);
        wake_up();
        unlock();
        wr(OFS_PLAN, 16'h9014);
        enter(1'b1);
        chk(16'({supply.main_sram_retain, supply.usb_rf_cfg_retain, supply.core_periph_retain,
                 supply.small_sram_retain, supply.flash_power_keep, supply.main_ldo_en,
                 supply.sys_power_en}), 16'h0050);
        rd(OFS_PLAN, rv);
        chk(rv, 16'h1014);
        wake_up();
        chk(16'(wsr_seen), 16'h0000);
        unlock();
        wr(OFS_PLAN, 16'h908B);
        enter(1'b1);
        chk(16'({supply.main_sram_retain, supply.usb_rf_cfg_retain, supply.core_periph_retain,
                 supply.small_sram_retain, supply.flash_power_keep, supply.main_ldo_en,
                 supply.sys_power_en}), 16'h000D);
        wake_up();
        chk(16'(wsr_seen), 16'h0001);
        rd(OFS_CAUSE, rv);
        chk(rv, 16'h0001);
        wr(OFS_CAUSE, 16'h0001);
        rd(OFS_CAUSE, rv);
        chk(rv, 16'h0000);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        wrap_up();
    end

endmodule : spp_sleep_power_planner_tb_top

`default_nettype wire
